// ---- hdl/pmrb_consts.svh ----
`ifndef PMRB_CONSTS_SVH
`define PMRB_CONSTS_SVH

`define PMRB_A_GAIN 8'h00
`define PMRB_A_INTEG 8'h01
`define PMRB_A_CTRL 8'h02
`define PMRB_A_VBUS_HI 8'h10
`define PMRB_A_VBUS_LO 8'h11
`define PMRB_A_VSNS_HI 8'h12
`define PMRB_A_VSNS_LO 8'h13
`define PMRB_A_VSUM_3 8'h14
`define PMRB_A_VSUM_2 8'h15
`define PMRB_A_VSUM_1 8'h16
`define PMRB_A_VSUM_0 8'h17
`define PMRB_A_ISUM_3 8'h18
`define PMRB_A_ISUM_2 8'h19
`define PMRB_A_ISUM_1 8'h1a
`define PMRB_A_ISUM_0 8'h1b
`define PMRB_A_OVF 8'h1c
`define PMRB_A_PWR_HI 8'h1d
`define PMRB_A_PWR_LO 8'h1e
`define PMRB_A_SMP_HI 8'h21
`define PMRB_A_SMP_LO 8'h22
`define PMRB_A_PSUM_4 8'h23
`define PMRB_A_PSUM_3 8'h24
`define PMRB_A_PSUM_2 8'h25
`define PMRB_A_PSUM_1 8'h26
`define PMRB_A_PSUM_0 8'h27
`define PMRB_A_PART 8'hfd
`define PMRB_A_MAKER 8'hfe
`define PMRB_A_REV 8'hff

`define PMRB_RST_GAIN 8'h00
`define PMRB_RST_INTEG 8'h0c
`define PMRB_RST_CTRL 8'h00

// gain_config fields
`define PMRB_B_CUR_WIDTH 7
`define PMRB_B_BUS_WIDTH 6
`define PMRB_F_CUR_GAIN 5:3
`define PMRB_F_BUS_GAIN 2:0
// integration_config fields
`define PMRB_F_SAMPLES 7:4
`define PMRB_B_SENSE_FILT 3
`define PMRB_B_BUS_FILT 2
`define PMRB_B_PIN_OVR 1
`define PMRB_B_SOFT_INT 0
// control fields
`define PMRB_F_OUT_SRC 7:6
`define PMRB_F_OUT_RANGE 5:4
`define PMRB_B_TIMEOUT 3
`define PMRB_B_SLEEP 2
`define PMRB_B_SLEEP_DIS 1
`define PMRB_B_RECALC 0

`define PMRB_SAMPLE_MAX_CODE 4'hb
`define PMRB_BUS_GAIN_MAX_CODE 3'h5
`define PMRB_TIMEOUT_MS 30
`define PMRB_CLK_KHZ 125000
`define PMRB_ADDR_W 7
`define PMRB_READ_BIT 1'b1

`endif

// ---- hdl/pmrb_pkg.sv ----
package pmrb_pkg;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PTR_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK = 9'h100
    } pmrb_state_t;

    typedef enum logic [1:0] {
        SRC_PIN_POWER = 2'h0,
        SRC_FREE_SENSE = 2'h1,
        SRC_FREE_BUS = 2'h2,
        SRC_FREE_POWER = 2'h3
    } pmrb_src_t;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl;
        logic sda;
        pmrb_state_t state;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [7:0] ptr;
        logic rw;
        logic sda_oe;
        logic [31:0] tmo_cnt;
        logic [7:0] gain_config;
        logic [7:0] integration_config;
        logic [7:0] control;
        logic sleep_req;
        logic recalc_pulse;
    } pmrb_state_s_t;
endpackage : pmrb_pkg

// ---- hdl/pmrb_top.sv ----
// How it works
// - block write stores bytes to consecutive registers
// - block read returns consecutive registers until nack
// - unused bits always read as zero
// - bits 7/6 pick 11-bit or 14-bit
// - current gain is two to the code
// - bus gain saturates at 32x
// - samples two to code, capped 2048
// - filter bits lengthen conversion by half
// - override bit swaps pin for soft control
// - with override, soft bit picks integrate/read in pin power mode
// - output select sets source and mode
// - range field sets output full scale
// - control bit 3 enables bus timeout
// - clock low over 30 ms resets protocol
// - sleep bit in read state enters sleep
// - sleep timer disable keeps read state
// - recalculate bit triggers immediate output update
`include "pmrb_consts.svh"

module pmrb_top #(
    parameter logic [6:0] DEV_ADDR = 7'h4c,
    parameter logic [7:0] PART_ID = 8'h11,  // arbitrary value
    parameter logic [7:0] MAKER_ID = 8'h22, // arbitrary value
    parameter logic [7:0] REV_ID = 8'h33,   // arbitrary value
    parameter int unsigned TIMEOUT_CYCLES = `PMRB_TIMEOUT_MS * `PMRB_CLK_KHZ
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic read_int_pin_in,
    input wire logic [9:0] bus_voltage_result_in,
    input wire logic [9:0] sense_voltage_result_in,
    input wire logic [9:0] power_result_in,
    input wire logic [24:0] bus_sample_accum_in,
    input wire logic [24:0] current_sample_accum_in,
    input wire logic [38:0] power_accum_in,
    input wire logic [11:0] sample_tally_in,
    input wire logic [2:0] overflow_in,
    input wire logic results_settled_in,
    output logic integrate_out,
    output logic sleep_req_out,
    output logic sleep_timer_disable_out,
    output logic recalc_out,
    output logic current_conv_width_sel_out,
    output logic bus_conv_width_sel_out,
    output logic [7:0] current_gain_mult_out,
    output logic [5:0] bus_gain_mult_out,
    output logic [11:0] sample_count_out,
    output logic sense_post_filter_on_out,
    output logic bus_post_filter_on_out,
    output logic [1:0] output_source_sel_out,
    output logic output_free_run_out,
    output logic [1:0] output_range_sel_out
);

    ////////////////////////////////////////////////////////////////////////////
    pmrb_pkg::pmrb_state_s_t s, next_s;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] rdata;
    logic [7:0] shifted;
    logic addr_match;
    logic [3:0] smp_code;
    logic [2:0] bgain_code;

    // level changes count only once the 2nd and 3rd stages agree
    always_comb begin
        scl_rise = (s.scl_sync[1] == s.scl_sync[2]) && s.scl_sync[2] && !s.scl;
        scl_fall = (s.scl_sync[1] == s.scl_sync[2]) && !s.scl_sync[2] && s.scl;
        start_seen = (s.sda_sync[1] == s.sda_sync[2]) && !s.sda_sync[2] && s.sda && s.scl;
        stop_seen = (s.sda_sync[1] == s.sda_sync[2]) && s.sda_sync[2] && !s.sda && s.scl;
        shifted = {s.shift[6:0], s.sda};
        addr_match = shifted[7:1] == DEV_ADDR;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux: unused bits tied to zero
    always_comb begin
        unique case (s.ptr)
            `PMRB_A_GAIN: rdata = s.gain_config;
            `PMRB_A_INTEG: rdata = s.integration_config;
            `PMRB_A_CTRL: rdata = s.control;
            `PMRB_A_VBUS_HI: rdata = bus_voltage_result_in[9:2];
            `PMRB_A_VBUS_LO: rdata = {bus_voltage_result_in[1:0], 6'h00};
            `PMRB_A_VSNS_HI: rdata = sense_voltage_result_in[9:2];
            `PMRB_A_VSNS_LO: rdata = {sense_voltage_result_in[1:0], 6'h00};
            `PMRB_A_VSUM_3: rdata = bus_sample_accum_in[24:17];
            `PMRB_A_VSUM_2: rdata = bus_sample_accum_in[16:9];
            `PMRB_A_VSUM_1: rdata = bus_sample_accum_in[8:1];
            `PMRB_A_VSUM_0: rdata = {bus_sample_accum_in[0], 7'h00};
            `PMRB_A_ISUM_3: rdata = current_sample_accum_in[24:17];
            `PMRB_A_ISUM_2: rdata = current_sample_accum_in[16:9];
            `PMRB_A_ISUM_1: rdata = current_sample_accum_in[8:1];
            `PMRB_A_ISUM_0: rdata = {current_sample_accum_in[0], 7'h00};
            `PMRB_A_OVF: rdata = {5'h00, overflow_in};
            `PMRB_A_PWR_HI: rdata = power_result_in[9:2];
            `PMRB_A_PWR_LO: rdata = {power_result_in[1:0], 6'h00};
            `PMRB_A_SMP_HI: rdata = sample_tally_in[11:4];
            `PMRB_A_SMP_LO: rdata = {sample_tally_in[3:0], 4'h0};
            `PMRB_A_PSUM_4: rdata = power_accum_in[38:31];
            `PMRB_A_PSUM_3: rdata = power_accum_in[30:23];
            `PMRB_A_PSUM_2: rdata = power_accum_in[22:15];
            `PMRB_A_PSUM_1: rdata = power_accum_in[14:7];
            `PMRB_A_PSUM_0: rdata = {power_accum_in[6:0], 1'b0};
            `PMRB_A_PART: rdata = PART_ID;
            `PMRB_A_MAKER: rdata = MAKER_ID;
            `PMRB_A_REV: rdata = REV_ID;
            default: rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.scl_sync = {s.scl_sync[1:0], scl_in};
        next_s.sda_sync = {s.sda_sync[1:0], sda_in};
        next_s.recalc_pulse = 1'b0;
        if (s.scl_sync[1] == s.scl_sync[2]) begin
            next_s.scl = s.scl_sync[2];
        end
        if (s.sda_sync[1] == s.sda_sync[2]) begin
            next_s.sda = s.sda_sync[2];
        end

        // clock-low watchdog
        if (s.control[`PMRB_B_TIMEOUT] && !s.scl) begin
            next_s.tmo_cnt = s.tmo_cnt + 32'h1;
        end else begin
            next_s.tmo_cnt = 32'h0;
        end

        if (start_seen) begin
            next_s.state = pmrb_pkg::ST_ADDR;
            next_s.bit_cnt = 3'h0;
            next_s.sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_s.state = pmrb_pkg::ST_IDLE;
            next_s.sda_oe = 1'b0;
        end else if (s.control[`PMRB_B_TIMEOUT] && s.tmo_cnt >= TIMEOUT_CYCLES) begin
            next_s.state = pmrb_pkg::ST_IDLE;
            next_s.sda_oe = 1'b0;
            next_s.tmo_cnt = 32'h0;
        end else begin
            unique case (s.state)
                pmrb_pkg::ST_IDLE: begin
                end
                pmrb_pkg::ST_ADDR, pmrb_pkg::ST_PTR, pmrb_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        next_s.shift = shifted;
                        next_s.bit_cnt = s.bit_cnt + 3'h1;
                        if (s.bit_cnt == 3'h7) begin
                            if (s.state == pmrb_pkg::ST_ADDR) begin
                                if (addr_match) begin
                                    next_s.rw = shifted[0];
                                    next_s.state = pmrb_pkg::ST_ADDR_ACK;
                                end else begin
                                    next_s.state = pmrb_pkg::ST_IDLE;
                                end
                            end else if (s.state == pmrb_pkg::ST_PTR) begin
                                next_s.ptr = shifted;
                                next_s.state = pmrb_pkg::ST_PTR_ACK;
                            end else begin
                                unique case (s.ptr)
                                    `PMRB_A_GAIN: next_s.gain_config = shifted;
                                    `PMRB_A_INTEG: next_s.integration_config = shifted;
                                    `PMRB_A_CTRL: begin
                                        next_s.control = shifted;
                                        next_s.sleep_req = shifted[`PMRB_B_SLEEP] && !integrate_out;
                                        next_s.recalc_pulse = shifted[`PMRB_B_RECALC];
                                    end
                                    default: begin
                                    end
                                endcase
                                next_s.ptr = s.ptr + 8'h1;
                                next_s.state = pmrb_pkg::ST_WACK;
                            end
                        end
                    end
                end
                pmrb_pkg::ST_ADDR_ACK, pmrb_pkg::ST_PTR_ACK, pmrb_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        if (!s.sda_oe) begin
                            next_s.sda_oe = 1'b1;
                        end else begin
                            next_s.sda_oe = 1'b0;
                            next_s.bit_cnt = 3'h0;
                            if (s.state == pmrb_pkg::ST_ADDR_ACK && s.rw == `PMRB_READ_BIT) begin
                                next_s.state = pmrb_pkg::ST_RDATA;
                                next_s.shift = rdata;
                                next_s.sda_oe = !rdata[7];
                                next_s.ptr = s.ptr + 8'h1;
                            end else if (s.state == pmrb_pkg::ST_ADDR_ACK) begin
                                next_s.state = pmrb_pkg::ST_PTR;
                            end else begin
                                next_s.state = pmrb_pkg::ST_WDATA;
                            end
                        end
                    end
                end
                pmrb_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        next_s.bit_cnt = s.bit_cnt + 3'h1;
                        if (s.bit_cnt == 3'h7) begin
                            next_s.sda_oe = 1'b0;
                            next_s.state = pmrb_pkg::ST_RACK;
                        end else begin
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.sda_oe = !s.shift[6];
                        end
                    end
                end
                pmrb_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (s.sda) begin
                            next_s.state = pmrb_pkg::ST_IDLE;
                        end else begin
                            next_s.state = pmrb_pkg::ST_ADDR_ACK;
                            next_s.sda_oe = 1'b1;
                        end
                    end
                end
            endcase
        end
        if (integrate_out) begin
            next_s.sleep_req = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '{scl_sync: 3'h7, sda_sync: 3'h7, scl: 1'b1, sda: 1'b1,
                   state: pmrb_pkg::ST_IDLE, shift: 8'h00, bit_cnt: 3'h0, ptr: 8'h00,
                   rw: 1'b0, sda_oe: 1'b0, tmo_cnt: 32'h0,
                   gain_config: `PMRB_RST_GAIN, integration_config: `PMRB_RST_INTEG,
                   control: `PMRB_RST_CTRL, sleep_req: 1'b0, recalc_pulse: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        smp_code = s.integration_config[`PMRB_F_SAMPLES];
        bgain_code = s.gain_config[`PMRB_F_BUS_GAIN];
        if (smp_code > `PMRB_SAMPLE_MAX_CODE) begin
            smp_code = `PMRB_SAMPLE_MAX_CODE;
        end
        if (bgain_code > `PMRB_BUS_GAIN_MAX_CODE) begin
            bgain_code = `PMRB_BUS_GAIN_MAX_CODE;
        end
        sda_out = 1'b0;
        sda_oe_out = s.sda_oe;
        if (s.control[`PMRB_F_OUT_SRC] != pmrb_pkg::SRC_PIN_POWER) begin
            integrate_out = 1'b1;
        end else if (s.integration_config[`PMRB_B_PIN_OVR]) begin
            integrate_out = s.integration_config[`PMRB_B_SOFT_INT];
        end else begin
            integrate_out = read_int_pin_in;
        end
        output_free_run_out = s.control[`PMRB_F_OUT_SRC] != pmrb_pkg::SRC_PIN_POWER;
        output_source_sel_out = s.control[`PMRB_F_OUT_SRC];
        output_range_sel_out = s.control[`PMRB_F_OUT_RANGE];
        sleep_req_out = s.sleep_req && !s.control[`PMRB_B_SLEEP_DIS];
        sleep_timer_disable_out = s.control[`PMRB_B_SLEEP_DIS];
        recalc_out = s.recalc_pulse;
        current_conv_width_sel_out = s.gain_config[`PMRB_B_CUR_WIDTH];
        bus_conv_width_sel_out = s.gain_config[`PMRB_B_BUS_WIDTH];
        current_gain_mult_out = 8'h01 << s.gain_config[`PMRB_F_CUR_GAIN];
        bus_gain_mult_out = 6'h01 << bgain_code;
        sample_count_out = 12'h001 << smp_code;
        sense_post_filter_on_out = s.integration_config[`PMRB_B_SENSE_FILT];
        bus_post_filter_on_out = s.integration_config[`PMRB_B_BUS_FILT];
    end

endmodule : pmrb_top

// ---- tb/pmrb_checker.sv ----
module pmrb_checker (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic integrate_out,
    input wire logic sleep_req_out,
    input wire logic sleep_timer_disable_out,
    input wire logic recalc_out,
    input wire logic [7:0] current_gain_mult_out,
    input wire logic [5:0] bus_gain_mult_out,
    input wire logic [11:0] sample_count_out,
    input wire logic [1:0] output_source_sel_out,
    input wire logic output_free_run_out,
    input wire logic [1:0] output_range_sel_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    // both lines high for a stretch: no transfer in flight
    sequence s_bus_idle;
        (scl_in && sda_in) [*8];
    endsequence
    sequence s_one_pulse;
        recalc_out ##1 !recalc_out;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_CUR_GAIN: assert property ($onehot(current_gain_mult_out))
        else $error("current gain not a power of two");
    AST_BUS_GAIN: assert property ($onehot(bus_gain_mult_out))
        else $error("bus gain not a power of two");
    AST_SAMPLES: assert property ($onehot(sample_count_out))
        else $error("sample count not a power of two");
    AST_FREE_RUN: assert property (output_free_run_out == (output_source_sel_out != 2'h0))
        else $error("free run flag disagrees with source select");
    AST_INTEG_FREE: assert property (output_free_run_out |-> integrate_out)
        else $error("free running mode not integrating");
    AST_RECALC: assert property ($rose(recalc_out) |-> s_one_pulse)
        else $error("recalc pulse longer than one cycle");
    AST_SLEEP_DIS: assert property (sleep_timer_disable_out && $past(sleep_timer_disable_out) |-> !sleep_req_out)
        else $error("sleep request while sleep timer disabled");
    AST_SLEEP_INT: assert property ($rose(sleep_req_out) |-> !$past(integrate_out))
        else $error("sleep requested while integrating");
    AST_IDLE_STABLE: assert property (s_bus_idle |=> $stable(current_gain_mult_out) && $stable(sample_count_out) && $stable(output_range_sel_out))
        else $error("configuration changed with bus idle");
endmodule : pmrb_checker

// ---- tb/pmrb_host.sv ----
module pmrb_host (
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] data [8];
    int nack_cnt = 0;
    logic k;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // extra wait before clock rise lets the client drop its ack first
    task automatic start;
        sda_low_out = 1'b0;
        #32 scl_out = 1'b1;
        #24 sda_low_out = 1'b1;
        #24 scl_out = 1'b0;
        #16;
    endtask : start
    task automatic stop;
        #16 sda_low_out = 1'b1;
        #24 scl_out = 1'b1;
        #24 sda_low_out = 1'b0;
        #16;
    endtask : stop
    // data moves well after the client sees the clock low, and the clock rises
    // only once a released ack has crossed the client's synchroniser
    task automatic bitx(input logic b, output logic r);
        #16 sda_low_out = !b;
        #24 scl_out = 1'b1;
        #16 r = sda_in;
        #8 scl_out = 1'b0;
    endtask : bitx
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], k);
        bitx(1'b1, ack);
        if (ack !== 1'b0) nack_cnt++;
    endtask : wbyte
    task automatic xfer(input logic [6:0] a, input logic [7:0] p, input int n, input logic rd);
        logic ack;
        nack_cnt = 0;
        start();
        wbyte({a, 1'b0}, ack);
        wbyte(p, ack);
        if (rd) begin
            start();
            wbyte({a, 1'b1}, ack);
        end
        for (int i = 0; i < n; i++) begin
            if (rd) begin
                for (int j = 7; j >= 0; j--) bitx(1'b1, data[i][j]);
                bitx(i == n - 1, k);
            end else begin
                wbyte(data[i], ack);
            end
        end
        stop();
    endtask : xfer
endmodule : pmrb_host

// ---- tb/pmrb_top_tb.sv ----
module pmrb_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] DEV = 7'h4c;
    localparam logic [7:0] PART = 8'h3a;  // arbitrary value
    localparam logic [7:0] MAKER = 8'h4b; // arbitrary value
    localparam logic [7:0] REV = 8'h6c;   // arbitrary value
    `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
    logic clock_in, rst_b_in, pin, host_low, scl, sda_w, sda_o, sda_oe, integ, slp, slp_dis;
    logic rcalc, cws, bws, sfo, bfo, ofr, k;
    logic [7:0] cgm;
    logic [5:0] bgm;
    logic [11:0] scnt, tally;
    logic [1:0] osrc, orng;
    logic [9:0] vb, vs, vp;
    logic [24:0] vsum, isum;
    logic [38:0] psum;
    logic [2:0] ov;
    logic [7:0] sh [3];
    int n_mismatch = 0, cmp_count = 0, cyc = 0, rc_cnt = 0, rc_base = 0;
    assign sda_w = !(host_low || (sda_oe && !sda_o));
    pmrb_top #(.DEV_ADDR(DEV), .PART_ID(PART), .MAKER_ID(MAKER), .REV_ID(REV),
        .TIMEOUT_CYCLES(200)) dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .read_int_pin_in(pin),
        .bus_voltage_result_in(vb), .sense_voltage_result_in(vs), .power_result_in(vp),
        .bus_sample_accum_in(vsum), .current_sample_accum_in(isum), .power_accum_in(psum),
        .sample_tally_in(tally), .overflow_in(ov), .results_settled_in(1'b1),
        .integrate_out(integ), .sleep_req_out(slp), .sleep_timer_disable_out(slp_dis),
        .recalc_out(rcalc), .current_conv_width_sel_out(cws), .bus_conv_width_sel_out(bws),
        .current_gain_mult_out(cgm), .bus_gain_mult_out(bgm), .sample_count_out(scnt),
        .sense_post_filter_on_out(sfo), .bus_post_filter_on_out(bfo),
        .output_source_sel_out(osrc), .output_free_run_out(ofr), .output_range_sel_out(orng));
    pmrb_host host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda_w));
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (rcalc === 1'b1) rc_cnt <= rc_cnt + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        logic [127:0] m1;
        logic [63:0] m2;
        m1 = {vb, 6'h00, vs, 6'h00, vsum, 7'h00, isum, 7'h00, 5'h00, ov, vp, 6'h00, 8'h00};
        m2 = {8'h00, tally, 4'h0, psum, 1'b0};
        if (a < 8'h03) return sh[a[1:0]];
        if (a[7:4] == 4'h1) return m1[127 - 8 * int'(a[3:0]) -: 8];
        if (a[7:3] == 5'h04) return m2[63 - 8 * int'(a[2:0]) -: 8];
        return (a == 8'hfd) ? PART : (a == 8'hfe) ? MAKER : (a == 8'hff) ? REV : 8'h00;
    endfunction : exp_reg
    task automatic new_meas;
        vb = 10'($urandom);
        vs = 10'($urandom);
        vp = 10'($urandom);
        vsum = 25'($urandom);
        isum = 25'($urandom);
        psum = {7'($urandom), $urandom};
        tally = 12'($urandom);
        ov = 3'($urandom);
    endtask : new_meas
    task automatic put(input logic [7:0] p, input int n);
        logic [7:0] a;
        host.xfer(DEV, p, n, 1'b0);
        `CHK(host.nack_cnt, 0)
        for (int i = 0; i < n; i++) begin
            a = p + 8'(i);
            if (a < 8'h03) sh[a[1:0]] = host.data[i];
        end
    endtask : put
    task automatic get(input logic [7:0] p);
        host.xfer(DEV, p, 8, 1'b1);
        for (int i = 0; i < 8; i++) `CHK(host.data[i], exp_reg(p + 8'(i)))
    endtask : get
    task automatic cfg_chk;
        `CHK(cws, sh[0][7])
        `CHK(bws, sh[0][6])
        `CHK(cgm, 8'h01 << sh[0][5:3])
        `CHK(bgm, 6'h01 << ((sh[0][2:0] > 3'h5) ? 3'h5 : sh[0][2:0]))
        `CHK(scnt, 12'h001 << ((sh[1][7:4] > 4'hb) ? 4'hb : sh[1][7:4]))
        `CHK({sfo, bfo}, sh[1][3:2])
        `CHK(integ, (sh[2][7:6] != 2'h0) ? 1'b1 : (sh[1][1] ? sh[1][0] : pin))
        `CHK({osrc, ofr}, {sh[2][7:6], sh[2][7:6] != 2'h0})
        `CHK(orng, sh[2][5:4])
        `CHK(slp_dis, sh[2][1])
    endtask : cfg_chk
    // holds the clock low mid-write, then tries one more data byte
    task automatic tmo_try(input logic exp_k);
        host.start();
        host.wbyte({DEV, 1'b0}, k);
        host.wbyte(8'h00, k);
        #2400;
        host.wbyte(8'h99, k);
        `CHK(k, exp_k)
        host.stop();
        if (!exp_k) sh[0] = 8'h99;
        get(8'h00);
    endtask : tmo_try
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b_in = 1'b0;
        pin = 1'b0;
        sh = '{8'h00, 8'h0c, 8'h00};
        void'($urandom(32'h7bba96e9));
        new_meas();
        repeat (8) @(negedge clock_in);
        rst_b_in = 1'b1;
        repeat (8) @(negedge clock_in);
        cfg_chk();
        get(8'h00);
        for (int t = 0; t < 4; t++) begin
            host.data[0] = (t == 0) ? 8'hff : (t == 1) ? 8'h2e : 8'($urandom);
            host.data[1] = (t == 0) ? 8'hff : (t == 1) ? 8'hc2 : 8'($urandom);
            host.data[2] = (t == 0) ? 8'hff : (t == 1) ? 8'h80 : 8'($urandom);
            pin = 1'($urandom);
            new_meas();
            put(8'h00, 3);
            cfg_chk();
            get(8'h00);
            get(8'h10);
            get(8'h18);
            get(8'h20);
        end
        put(8'h10, 2);
        get(8'h10);
        for (int i = 0; i < 4; i++) host.data[i] = 8'($urandom);
        put(8'hfe, 4);
        get(8'hfd);
        host.data[0] = 8'h77;
        host.xfer(DEV ^ 7'h01, 8'h00, 1, 1'b0);
        `CHK(host.nack_cnt, 3)
        get(8'h00);
        host.data[0] = 8'h02;
        host.data[1] = 8'h00;
        put(8'h01, 2);
        host.data[0] = 8'h04;
        put(8'h02, 1);
        `CHK(slp, 1'b1)
        rc_base = rc_cnt;
        host.data[0] = 8'h07;
        put(8'h02, 1);
        `CHK(slp, 1'b0)
        `CHK(rc_cnt - rc_base, 1)
        cfg_chk();
        host.data[0] = 8'h08;
        put(8'h02, 1);
        tmo_try(1'b1);
        host.data[0] = 8'h00;
        put(8'h02, 1);
        tmo_try(1'b0);
        cfg_chk();
        wrap_up();
    end
endmodule : pmrb_top_tb

bind pmrb_top pmrb_checker chk (.clock_in, .rst_b_in, .scl_in, .sda_in, .integrate_out,
    .sleep_req_out, .sleep_timer_disable_out, .recalc_out, .current_gain_mult_out,
    .bus_gain_mult_out, .sample_count_out, .output_source_sel_out, .output_free_run_out,
    .output_range_sel_out);
